// file: src/ctw_core_timer.sv
// Core timer: prescaled ripple counter, overflow, periodic interrupt, watchdog, APB slave
//
// Implementation choice: the APB interface to the registers.
`include "ctw_regs.svh"
`default_nettype none
module ctw_core_timer
   import ctw_pkg::*;
#(
   parameter bit                       WATCHDOG_EN   = 1'b1,
   parameter logic [`CTW_CHAIN_W-1:0]  POR_DELAY_CYC = `CTW_CHAIN_W'(`CTW_POR_DELAY_CYC)
) (
   input  wire logic                   MCLK_I,        // Bus clock, 125 MHz
   input  wire logic                   RST_N_I,       // External reset, async, active low
   input  wire logic                   PSEL_I,        // APB select
   input  wire logic                   PENABLE_I,     // APB access phase
   input  wire logic                   PWRITE_I,      // APB direction, high for write
   input  wire logic [`CTW_ADDR_W-1:0] PADDR_I,       // APB byte address
   input  wire logic [31:0]            PWDATA_I,      // APB write data
   input  wire logic [3:0]             PSTRB_I,       // APB byte strobes
   output logic      [31:0]            PRDATA_O,      // APB read data
   output logic                        PREADY_O,      // APB ready
   output logic                        PSLVERR_O,     // APB error, unmapped address
   input  wire logic                   CPU_IRQ_MASK_I,// CPU interrupt mask bit
   input  wire logic                   WAIT_I,        // CPU in wait mode
   input  wire logic                   STOP_I,        // CPU in stop mode
   output logic                        IRQ_O,         // Core timer interrupt request
   output logic                        WAKE_O,        // Wake request out of wait mode
   output logic                        RESET_REQ_O    // Internal device reset request
);

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   if (POR_DELAY_CYC < `CTW_CHAIN_W'(2)) begin : g_chk_por
      $error("power-on delay must be at least two clocks");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam logic [`CTW_ADDR_W-1:0] ADDR_CSR = `CTW_ADDR_W'(`CTW_CSR_IDX << 2);
   localparam logic [`CTW_ADDR_W-1:0] ADDR_CNT = `CTW_ADDR_W'(`CTW_CNT_IDX << 2);
   localparam logic [`CTW_ADDR_W-1:0] ADDR_WDC = `CTW_ADDR_W'(`CTW_WDC_IDX << 2);
   localparam int                     OVF_W    = `CTW_PRESC_W + `CTW_CNT_W;

   ctw_state_t              state;
   logic [`CTW_CHAIN_W-1:0] chain;
   logic [`CTW_WDOG_W-1:0]  wdog;
   logic                    overflow_flag;
   logic                    periodic_irq_flag;
   logic                    overflow_irq_enable;
   logic                    periodic_irq_enable;
   ctw_rate_t               rate_sel;

   logic                    running;
   logic                    ovf_event;
   logic                    per_event;
   logic                    wdog_timeout;
   logic                    int_reset;
   logic                    acc_done;
   logic                    wr_csr;
   logic                    wr_wdc;
   logic                    mapped;
   logic                    irq_cond;
   logic [`CTW_CNT_W-1:0]   core_count_value_reg;
   logic [7:0]              core_control_status_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // True when the low width bits of the chain are all ones, about to carry out
   function automatic logic low_bits_full(input logic [`CTW_CHAIN_W-1:0] c,
                                          input int                      width);
      logic full;
      full = 1'b1;
      for (int i = 0; i < `CTW_CHAIN_W; i++) begin
         if (i < width && !c[i]) begin
            full = 1'b0;
         end
      end
      return full;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Chain events

   // Counter byte sits above the divide-by-four prescaler
   assign core_count_value_reg = chain[`CTW_PRESC_W +: `CTW_CNT_W];
   assign running      = (state == CTW_ST_RUN);
   // Counter byte wraps FF to 00 every 1024 bus clocks
   assign ovf_event    = running && low_bits_full(chain, OVF_W);
   // Selected tap carries out every 2^(14+rate) bus clocks
   assign per_event    = running &&
                         low_bits_full(chain, `CTW_PER_BASE + int'(rate_sel));
   // Eighth periodic event while watchdog stage full
   assign wdog_timeout = WATCHDOG_EN && per_event &&
                         (wdog == {`CTW_WDOG_W{1'b1}});
   assign int_reset    = (state == CTW_ST_POR);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign acc_done = PSEL_I && PENABLE_I && PREADY_O;
   assign mapped   = (PADDR_I == ADDR_CSR) || (PADDR_I == ADDR_CNT) || (PADDR_I == ADDR_WDC);
   assign wr_csr   = acc_done && PWRITE_I && (PADDR_I == ADDR_CSR) && PSTRB_I[0];
   // Writing zero to bit 0 clears the watchdog
   assign wr_wdc   = acc_done && PWRITE_I && (PADDR_I == ADDR_WDC) && PSTRB_I[0] &&
                     !PWDATA_I[`CTW_B_WDC];

   // Reset bits read back as zero
   assign core_control_status_reg = {overflow_flag, periodic_irq_flag, overflow_irq_enable,
                                     periodic_irq_enable, 2'b00, rate_sel};

   // Enabled overflow or periodic condition; CPU mask gates only IRQ_O, not WAKE_O
   assign irq_cond = ((overflow_flag && overflow_irq_enable) ||
                      (periodic_irq_flag && periodic_irq_enable));

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: power-on delay, run, stop and restart delay

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= CTW_ST_POR;
      end else begin
         case (state)
            CTW_ST_POR, CTW_ST_WAKE: begin
               if (chain == POR_DELAY_CYC - `CTW_CHAIN_W'(1)) begin
                  state <= CTW_ST_RUN;
               end
            end
            CTW_ST_RUN: begin
               if (wdog_timeout) begin
                  state <= CTW_ST_POR;
               end else if (STOP_I) begin
                  state <= CTW_ST_STOP;
               end
            end
            CTW_ST_STOP: begin
               if (!STOP_I) begin
                  state <= CTW_ST_WAKE;
               end
            end
            default: begin
               state <= CTW_ST_POR;
            end
         endcase
      end
   end

   // Counter chain, cleared at each phase change; counts on through wait mode
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         chain <= '0;
      end else if ((state == CTW_ST_POR || state == CTW_ST_WAKE) &&
                   chain == POR_DELAY_CYC - `CTW_CHAIN_W'(1)) begin
         chain <= '0;
      end else if (state == CTW_ST_STOP || (running && (STOP_I || wdog_timeout))) begin
         chain <= '0;
      end else begin
         chain <= chain + `CTW_CHAIN_W'(1);
      end
   end

   // Watchdog divide-by-eight stage; clear touches only this stage
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wdog <= '0;
      end else if (!running || wr_wdc) begin
         wdog <= '0;
      end else if (per_event) begin
         wdog <= wdog + `CTW_WDOG_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control and status register

   // Enables and rate select; internal reset restores defaults
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         overflow_irq_enable <= 1'(`CTW_CSR_RESET >> `CTW_B_OVF_EN);
         periodic_irq_enable <= 1'(`CTW_CSR_RESET >> `CTW_B_PER_EN);
         rate_sel            <= ctw_rate_t'(`CTW_CSR_RESET);
      end else if (int_reset) begin
         overflow_irq_enable <= 1'(`CTW_CSR_RESET >> `CTW_B_OVF_EN);
         periodic_irq_enable <= 1'(`CTW_CSR_RESET >> `CTW_B_PER_EN);
         rate_sel            <= ctw_rate_t'(`CTW_CSR_RESET);
      end else if (wr_csr) begin
         overflow_irq_enable <= PWDATA_I[`CTW_B_OVF_EN];
         periodic_irq_enable <= PWDATA_I[`CTW_B_PER_EN];
         rate_sel            <= PWDATA_I[`CTW_B_RATE_HI:`CTW_B_RATE_LO];
      end
   end

   // Overflow flag; a wrap in the clearing cycle wins over the clear
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         overflow_flag <= 1'b0;
      end else if (int_reset) begin
         overflow_flag <= 1'b0;
      end else if (ovf_event) begin
         overflow_flag <= 1'b1;
      end else if (wr_csr && PWDATA_I[`CTW_B_OVF_RST]) begin
         overflow_flag <= 1'b0;
      end
   end

   // Periodic flag; a tap event in the clearing cycle wins over the clear
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         periodic_irq_flag <= 1'b0;
      end else if (int_reset) begin
         periodic_irq_flag <= 1'b0;
      end else if (per_event) begin
         periodic_irq_flag <= 1'b1;
      end else if (wr_csr && PWDATA_I[`CTW_B_PER_RST]) begin
         periodic_irq_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave: setup cycle loads answer, ready in the first access cycle

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h0000_0000;
      end else if (PSEL_I && !PENABLE_I) begin
         PREADY_O  <= 1'b1;
         PSLVERR_O <= !mapped;
         if (PWRITE_I || PADDR_I == ADDR_WDC || !mapped) begin
            PRDATA_O <= 32'h0000_0000;
         end else if (PADDR_I == ADDR_CSR) begin
            PRDATA_O <= {24'h00_0000, core_control_status_reg};
         end else begin
            PRDATA_O <= {24'h00_0000, core_count_value_reg};
         end
      end else begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt, wake and internal reset outputs

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         IRQ_O       <= 1'b0;
         WAKE_O      <= 1'b0;
         RESET_REQ_O <= 1'b1;
      end else begin
         IRQ_O       <= irq_cond && !CPU_IRQ_MASK_I;
         WAKE_O      <= irq_cond && WAIT_I;
         RESET_REQ_O <= int_reset || wdog_timeout;
      end
   end

endmodule
`default_nettype wire

// file: src/ctw_regs.svh
// Register offsets, field positions, reset values and timing counts of the core timer
//
// Operation
// - Bus clock divided by four advances an 8-bit counter starting the chain.
// - Live counter value reads from a read-only register; reset clears it.
// - Overflow comes from the last counter stage, once per 1024 bus clocks.
// - Overflow flag sets when the 8-bit counter wraps from all ones to zero.
// - Overflow requests interrupt when flag and enable set and CPU mask clear.
// - Writing one to overflow-reset bit clears the flag; writing the flag bit does nothing.
// - Reset clears overflow flag and overflow interrupt enable.
// - Periodic flag sets on selected tap; interrupt if enabled and mask clear.
// - Writing one to periodic-reset bit clears the periodic flag; reset clears it too.
// - Two rate bits pick periods of 2^14, 2^15, 2^16 or 2^17 bus clocks.
// - Reset sets both rate bits, control register resets to 0000 0011.
// - Watchdog timeout is the periodic tap divided by a further eight.
// - Watchdog clear resets only the divide-by-eight stage; timeout seven to eight periods.
// - Watchdog timeout generates an internal reset, then the reset vector is fetched.
// - Watchdog presence is a build parameter enabling or removing timeout reset.
// - Power-up clears chain, holds reset until the 4064-clock tap, clears again.
// - External reset at any time clears the entire counter chain.
// - Timer keeps counting in wait mode; enabled interrupt wakes the processor.
// - Timer cleared entering stop mode and again after restart delay on exit.
`ifndef CTW_REGS_SVH
`define CTW_REGS_SVH

// Register indices; byte address is four times the index
`define CTW_CSR_IDX        16'h0008
`define CTW_CNT_IDX        16'h0009
`define CTW_WDC_IDX        16'h0FF0
`define CTW_ADDR_W         16

// Control and status field positions
`define CTW_B_OVF_FLAG     7
`define CTW_B_PER_FLAG     6
`define CTW_B_OVF_EN       5
`define CTW_B_PER_EN       4
`define CTW_B_OVF_RST      3
`define CTW_B_PER_RST      2
`define CTW_B_RATE_HI      1
`define CTW_B_RATE_LO      0
`define CTW_B_WDC          0
`define CTW_CSR_RESET      8'h03

// Chain layout and timing counts in bus clocks
`define CTW_CHAIN_W        17
`define CTW_PRESC_W        2
`define CTW_CNT_W          8
`define CTW_PER_BASE       14
`define CTW_WDOG_W         3
`define CTW_POR_DELAY_CYC  4064

`endif

// file: src/ctw_pkg.sv
// Types shared by the core timer
`default_nettype none
package ctw_pkg;
   // Sequencing of the timer chain
   typedef enum logic [1:0] {
      CTW_ST_POR,
      CTW_ST_RUN,
      CTW_ST_STOP,
      CTW_ST_WAKE
   } ctw_state_t;

   typedef logic [1:0] ctw_rate_t;
endpackage
`default_nettype wire

// file: tb/ctw_cpu_model.sv
// Bus master model of the CPU core that reaches the timer registers
`default_nettype none
module ctw_cpu_model (
   input  wire logic        clk_i,      // Bus clock
   input  wire logic [31:0] prdata_i,   // Read data
   input  wire logic        pready_i,   // Ready
   input  wire logic        pslverr_i,  // Error
   output logic             psel_o,     // Select
   output logic             penable_o,  // Access phase
   output logic             pwrite_o,   // Direction
   output logic      [15:0] paddr_o,    // Byte address
   output logic      [31:0] pwdata_o,   // Write data
   output logic      [3:0]  pstrb_o     // Byte strobes
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial begin
      {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
      pstrb_o = 4'hF;
   end
   // One transfer, held until ready; released lines show inverted junk
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= wr;
      paddr_o <= a;
      pwdata_o <= wd;
      @(posedge clk_i);
      penable_o <= 1'b1;
      rd = 'x;
      err = 1'bx;
      // Wait for ready as long as it takes; only the bench timeout ends a hang
      do begin
         @(posedge clk_i);
      end while (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~a;
      pwdata_o <= ~wd;
   endtask
endmodule
`default_nettype wire

// file: tb/ctw_core_timer_props.sv
// Concurrent checks on the core timer ports
`default_nettype none
module ctw_core_timer_props #(parameter int POR_DELAY_CYC = 4064) (
   input wire logic        MCLK_I,          // Bus clock
   input wire logic        RST_N_I,         // Reset, active low
   input wire logic        PSEL_I,          // Select
   input wire logic        PENABLE_I,       // Access phase
   input wire logic        PWRITE_I,        // Direction
   input wire logic [15:0] PADDR_I,         // Byte address
   input wire logic [31:0] PRDATA_O,        // Read data
   input wire logic        PREADY_O,        // Ready
   input wire logic        PSLVERR_O,       // Error
   input wire logic        CPU_IRQ_MASK_I,  // CPU mask
   input wire logic        WAIT_I,          // Wait mode
   input wire logic        STOP_I,          // Stop mode
   input wire logic        IRQ_O,           // Interrupt request
   input wire logic        WAKE_O,          // Wake request
   input wire logic        RESET_REQ_O      // Internal reset request
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   int  hold_cnt;
   wire logic unm = !(PADDR_I inside {16'h0020, 16'h0024, 16'h3FC0});
   ////////////////////////////////////////////////////////////////////////////////
   // Length of the current internal reset request
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) hold_cnt <= 0;
      else hold_cnt <= RESET_REQ_O ? hold_cnt + 1 : 0;
   end
   a_ready_first: assert property (PSEL_I && PENABLE_I && $past(PSEL_I && !PENABLE_I)
      |-> PREADY_O) else $error("ready missing in first access cycle");
   a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
   a_unmapped_err: assert property (PREADY_O && unm |-> PSLVERR_O && PRDATA_O == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (PREADY_O && !unm |-> !PSLVERR_O) else $error("bad error");
   a_rdata_byte: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
      else $error("upper read bits set");
   a_irq_masked: assert property ($past(CPU_IRQ_MASK_I) |-> !IRQ_O)
      else $error("interrupt while masked");
   a_wake_wait: assert property (!$past(WAIT_I) |-> !WAKE_O) else $error("wake outside wait");
   a_stop_clear: assert property (STOP_I && $past(STOP_I, 3) && PREADY_O && !PWRITE_I &&
      PADDR_I == 16'h0024 |-> PRDATA_O == 32'h0) else $error("count runs in stop");
   a_por_hold: assert property ($rose(RST_N_I) |-> RESET_REQ_O [*8])
      else $error("power-on delay too short");
   a_por_bound: assert property (RESET_REQ_O |-> hold_cnt <= POR_DELAY_CYC + 4)
      else $error("power-on delay too long");
   c_refused: cover property (PREADY_O && PSLVERR_O);
   c_irq: cover property (IRQ_O);
   c_wake: cover property (WAKE_O);
   c_run: cover property ($fell(RESET_REQ_O));
endmodule
bind ctw_core_timer ctw_core_timer_props #(.POR_DELAY_CYC(POR_DELAY_CYC)) ctw_core_timer_props_inst (.*);
`default_nettype wire

// file: tb/ctw_core_timer_test.sv
// Self-checking bench of the core timer
`default_nettype none
module ctw_core_timer_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int POR = 16;  // Shortened power-on delay
   typedef struct packed {
      logic wr; logic [15:0] a; logic [31:0] wd; logic [31:0] rd; logic err;
   } ctw_row_t;
   logic        clk = 0, rst_n = 0, mask = 0, wt = 0, stp = 0, err;
   wire logic   psel, penable, pwrite, pready, pslverr, irq, wake, rreq;
   wire logic [15:0] paddr;
   wire logic [31:0] pwdata, prdata;
   wire logic [3:0]  pstrb;
   logic [31:0] rd, rd2;
   int          mismatches = 0, n_checks = 0;
   ctw_row_t    rows [7] = '{'{0, 16'h0020, 0, 32'h03, 0}, '{1, 16'h3FC0, 0, 0, 0},
      '{1, 16'h0020, 32'h30, 0, 0}, '{0, 16'h0020, 0, 32'h30, 0}, '{0, 16'h0028, 0, 0, 1},
      '{0, 16'h3FC0, 0, 0, 0}, '{1, 16'h0020, 32'h03, 0, 0}};
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, design and bus master
   always #4 clk = ~clk;
   ctw_core_timer #(.POR_DELAY_CYC(17'(POR))) ctw_core_timer_inst (.MCLK_I(clk),
      .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .CPU_IRQ_MASK_I(mask), .WAIT_I(wt), .STOP_I(stp), .IRQ_O(irq),
      .WAKE_O(wake), .RESET_REQ_O(rreq));
   ctw_cpu_model ctw_cpu_model_inst (.clk_i(clk), .prdata_i(prdata), .pready_i(pready),
      .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
   ////////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xf(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      ctw_cpu_model_inst.xfer(wr, a, wd, rd, err);
   endtask
   // Bounded wait: 0 for interrupt high, 1 for reset request low
   task automatic wait_until(input int which, input int lim);
      for (int n = 0; n < lim; n++) begin
         if (which == 0 ? irq === 1'b1 : rreq === 1'b0) return;
         @(posedge clk);
      end
      mismatches++;
      $display("mismatch wait %0d expected event seen timeout", which);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #(8 * 30000);
      mismatches++;
      $display("mismatch run expected end seen timeout");
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("req_por", rreq, 1);
      wait_until(1, POR + 20);
      foreach (rows[i]) begin
         xf(rows[i].wr, rows[i].a, rows[i].wd);
         chk("err", err, rows[i].err);
         if (!rows[i].wr) chk("rdata", rd, rows[i].rd);
      end
      $display("test registers done");
      xf(0, 16'h0024, 0);
      rd2 = rd;
      @(posedge clk);
      xf(0, 16'h0024, 0);
      chk("count_step", (rd - rd2) & 32'hFF, 1);
      $display("test count done");
      xf(1, 16'h3FC0, 0);
      xf(1, 16'h0020, 32'h20);
      wait_until(0, 1100);
      xf(0, 16'h0020, 0);
      chk("ovf_set", rd, 32'hA0);
      xf(1, 16'h0020, 32'hA0);
      xf(0, 16'h0020, 0);
      chk("ovf_keep", rd, 32'hA0);
      xf(1, 16'h0020, 32'h28);
      xf(0, 16'h0020, 0);
      chk("ovf_clr", rd, 32'h20);
      chk("irq_off", irq, 0);
      $display("test overflow done");
      xf(1, 16'h0020, 32'h10);
      wait_until(0, 17000);
      xf(0, 16'h0020, 0);
      chk("per_set", rd & 32'h50, 32'h50);
      wt <= 1'b1;
      repeat (3) @(posedge clk);
      chk("wake", wake, 1);
      mask <= 1'b1;
      repeat (3) @(posedge clk);
      chk("irq_mask", irq, 0);
      xf(1, 16'h0020, 32'h14);
      xf(0, 16'h0020, 0);
      chk("per_clr", rd & 32'h40, 0);
      wt <= 1'b0;
      mask <= 1'b0;
      $display("test periodic done");
      stp <= 1'b1;
      repeat (4) @(posedge clk);
      xf(0, 16'h0024, 0);
      chk("stop_count", rd, 0);
      stp <= 1'b0;
      $display("test stop done");
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk("req_ext", rreq, 1);
      rst_n <= 1'b1;
      xf(0, 16'h0020, 0);
      chk("csr_reset", rd, 32'h03);
      wait_until(1, POR + 20);
      $display("test reset done");
      stop_test();
   end
endmodule
`default_nettype wire
